//--- verilog/mirc_params.svh
// Register map, field positions and reset values of the interrupt control
`ifndef MIRC_PARAMS_SVH
`define MIRC_PARAMS_SVH

`define MIRC_OFF_EDGE      12'h000
`define MIRC_OFF_CTRL_A    12'h004
`define MIRC_OFF_CTRL_B    12'h008
`define MIRC_OFF_CTRL_C    12'h00C
`define MIRC_OFF_GROUPED   12'h010
`define MIRC_OFF_STATUS    12'h014
`define MIRC_OFF_MASK      12'h018

`define MIRC_RST_BYTE      8'h00
`define MIRC_EDGE_MASK     8'h0F
`define MIRC_CTRL_MASK     8'h7F
`define MIRC_CTRL_C_MASK   8'h77
`define MIRC_GRP_MASK      8'hFF
`define MIRC_EV_MASK       8'h7F
`define MIRC_EV_RST        7'h00
`define MIRC_RST_WORD      32'h0000_0000

// Edge-select field positions
`define MIRC_SEL_A_LO      0
`define MIRC_SEL_B_LO      2
// Control register A fields
`define MIRC_A_GIE         0
`define MIRC_A_PIN_A_EN    1
`define MIRC_A_PIN_B_EN    2
`define MIRC_A_USB_EN      3
`define MIRC_A_PIN_A_FLG   4
`define MIRC_A_PIN_B_FLG   5
`define MIRC_A_USB_FLG     6
// Control register B fields (USB token sources)
`define MIRC_B_EN_LO       0
`define MIRC_B_FLG_LO      4
// Control register C fields
`define MIRC_C_GRP_EN      0
`define MIRC_C_SER_EN      1
`define MIRC_C_LV_EN       2
`define MIRC_C_GRP_FLG     4
`define MIRC_C_SER_FLG     5
`define MIRC_C_LV_FLG      6
// Grouped timer register: enables low nibble, flags high nibble
`define MIRC_G_EN_LO       0
`define MIRC_G_FLG_LO      4
`define MIRC_FLG_OFS       4
// Event status bit positions
`define MIRC_EV_PIN_A      0
`define MIRC_EV_PIN_B      1
`define MIRC_EV_USB        2
`define MIRC_EV_SER        3
`define MIRC_EV_LV         4
`define MIRC_EV_GRP        5
`define MIRC_EV_ACCEPT     6

`endif

//--- verilog/mirc_pkg.sv
// Types shared by the interrupt control block
package mirc_pkg;
   typedef enum logic [1:0] {
      MIRC_EDGE_OFF  = 2'h0,
      MIRC_EDGE_RISE = 2'h1,
      MIRC_EDGE_FALL = 2'h2,
      MIRC_EDGE_BOTH = 2'h3
   } mirc_edge_t;

   typedef enum logic [1:0] {
      MIRC_ST_RUN     = 2'h0,
      MIRC_ST_SUSPEND = 2'h1
   } mirc_state_t;
endpackage

//--- verilog/mirc_intc.sv
// Interrupt request control with APB register access
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "mirc_params.svh"
// Summary of operation
// [R1] An accepted enabled request suspends the main program for servicing.
// [R2] Each of two external pins raises a request on selected edges.
// [R3] Timers, low voltage, serial module and USB engine raise requests.
// [R4] Flags set on their trigger regardless of enable settings.
// [R5] Software writes per-source enables; registers hold enable and flag.
// [R6] Timer P and A match flags and enables sit in grouped register.
// [R7] Pin B edge field bits 3:2: off, rising, falling, both.
// [R8] Pin A edge field bits 1:0 decodes the same way.
// [R9] Edge register bits 7:4 read zero; implemented bits reset zero.
// [R10] Control A bit 6 is the USB engine request flag.
// [R11] Control A bit 5 is pin B flag, bit 4 pin A flag.
// [R12] Control A bits 3..0: USB, pin B, pin A, global enables.
// [R13] Control C bit 6 low voltage flag, bit 2 its enable.
// [R14] Control C bit 5 serial module flag, bit 1 its enable.
// [R15] Request passes only with flag, own enable and global enable set.
// [R16] Flags are read/write; writing zero clears a pending request.
// [R17] Grouped flag sets when any enabled timer match flag is set.

module mirc_intc (
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [1:0]  external_request_pin_i,
   input  wire logic        usb_serial_engine_req_i,
   input  wire logic [2:0]  usb_token_req_i,
   input  wire logic        low_voltage_detector_req_i,
   input  wire logic        serial_module_req_i,
   input  wire logic [1:0]  timer_p_match_i,
   input  wire logic [1:0]  timer_a_match_i,
   input  wire logic        service_done_i,
   output logic             cpu_irq_o,
   output logic             main_suspend_o,
   output mirc_pkg::mirc_state_t state_o,
   output logic             irq_o
);
   import mirc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] edge_sel_q;
   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] ctrl_c_q;
   logic [7:0] grp_q;
   logic [6:0] ev_status_q;
   logic [6:0] ev_mask_q;
   logic [1:0] pin_q;
   logic [1:0] pin_hit;
   logic [3:0] tmr_hit;
   logic       wr_en;
   logic       rd_en;
   logic       addr_ok;
   logic [7:0] wbyte;
   logic       accept;
   logic       any_req;
   logic [6:0] ev_set;
   mirc_state_t state_q;

   // Per-register write strobes
   logic       wr_edge;
   logic       wr_ctrl_a;
   logic       wr_ctrl_b;
   logic       wr_ctrl_c;
   logic       wr_grp;
   logic       wr_status;
   logic       wr_mask;
   logic       grp_any;
   logic [8:0] src_req;
   logic [31:0] rd_mux;
   logic [31:0] prdata_q;

   function automatic logic wr_hit(input logic [11:0] a,
                                   input logic [11:0] off);
      wr_hit = (a == off);
   endfunction

   // Flag counts only while its own enable is set
   function automatic logic gated(input logic flag,
                                  input logic en);
      gated = flag & en;
   endfunction

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic prev,
                                     input logic cur);
      logic rise;
      logic fall;
      rise = ~prev & cur;
      fall = prev & ~cur;
      case (mirc_edge_t'(sel))
         MIRC_EDGE_RISE: edge_hit = rise;
         MIRC_EDGE_FALL: edge_hit = fall;
         MIRC_EDGE_BOTH: edge_hit = rise | fall;
         default:        edge_hit = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped address
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign rd_en     = psel_i & ~pwrite_i;
   assign wbyte     = pwdata_i[7:0];
   assign pready_o  = 1'b1;
   assign addr_ok   = wr_hit(paddr_i, `MIRC_OFF_EDGE)
                    | wr_hit(paddr_i, `MIRC_OFF_CTRL_A)
                    | wr_hit(paddr_i, `MIRC_OFF_CTRL_B)
                    | wr_hit(paddr_i, `MIRC_OFF_CTRL_C)
                    | wr_hit(paddr_i, `MIRC_OFF_GROUPED)
                    | wr_hit(paddr_i, `MIRC_OFF_STATUS)
                    | wr_hit(paddr_i, `MIRC_OFF_MASK);
   assign pslverr_o = psel_i & penable_i & ~addr_ok;

   // Write strobes, one per register
   assign wr_edge   = wr_en & wr_hit(paddr_i, `MIRC_OFF_EDGE);
   assign wr_ctrl_a = wr_en & wr_hit(paddr_i, `MIRC_OFF_CTRL_A);
   assign wr_ctrl_b = wr_en & wr_hit(paddr_i, `MIRC_OFF_CTRL_B);
   assign wr_ctrl_c = wr_en & wr_hit(paddr_i, `MIRC_OFF_CTRL_C);
   assign wr_grp    = wr_en & wr_hit(paddr_i, `MIRC_OFF_GROUPED);
   assign wr_status = wr_en & wr_hit(paddr_i, `MIRC_OFF_STATUS);
   assign wr_mask   = wr_en & wr_hit(paddr_i, `MIRC_OFF_MASK);

   always_comb begin
      rd_mux = `MIRC_RST_WORD;
      if (rd_en) begin
         case (paddr_i)
            `MIRC_OFF_EDGE:    rd_mux[7:0] = edge_sel_q;           // R9
            `MIRC_OFF_CTRL_A:  rd_mux[7:0] = ctrl_a_q;
            `MIRC_OFF_CTRL_B:  rd_mux[7:0] = ctrl_b_q;
            `MIRC_OFF_CTRL_C:  rd_mux[7:0] = ctrl_c_q;
            `MIRC_OFF_GROUPED: rd_mux[7:0] = grp_q;
            `MIRC_OFF_STATUS:  rd_mux[6:0] = ev_status_q;
            `MIRC_OFF_MASK:    rd_mux[6:0] = ev_mask_q;
            default:           rd_mux = `MIRC_RST_WORD;
         endcase
      end
   end

   // Read word captured in the setup cycle, held through the access
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata_q <= `MIRC_RST_WORD;
      end else if (rd_en && !penable_i) begin
         prdata_q <= rd_mux;
      end else if (!rd_en) begin
         prdata_q <= `MIRC_RST_WORD;
      end
   end

   assign prdata_o = prdata_q;

   ////////////////////////////////////////////////////////////////////////
   // External pin edge detection
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_q <= 2'h0;
      end else begin
         pin_q <= external_request_pin_i;
      end
   end

   assign pin_hit[0] = edge_hit(edge_sel_q[`MIRC_SEL_A_LO +: 2],
                                pin_q[0], external_request_pin_i[0]); // R8 R2
   assign pin_hit[1] = edge_hit(edge_sel_q[`MIRC_SEL_B_LO +: 2],
                                pin_q[1], external_request_pin_i[1]); // R7 R2
   for (genvar t = 0; t < 2; t++) begin : g_tmr
      assign tmr_hit[2 * t]     = timer_p_match_i[t];               // R6
      assign tmr_hit[2 * t + 1] = timer_a_match_i[t];               // R6
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge select: only the two pin fields are kept
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         edge_sel_q <= `MIRC_RST_BYTE;                               // R9
      end else if (wr_edge) begin
         edge_sel_q <= wbyte & `MIRC_EDGE_MASK;                      // R9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control A: software writes, hardware set wins over write-zero
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_a_q <= `MIRC_RST_BYTE;                                 // R12
      end else begin
         if (wr_ctrl_a) begin
            ctrl_a_q <= wbyte & `MIRC_CTRL_MASK;                     // R5 R16
         end
         if (pin_hit[0]) begin
            ctrl_a_q[`MIRC_A_PIN_A_FLG] <= 1'b1;                     // R11 R4
         end
         if (pin_hit[1]) begin
            ctrl_a_q[`MIRC_A_PIN_B_FLG] <= 1'b1;                     // R11 R4
         end
         if (usb_serial_engine_req_i) begin
            ctrl_a_q[`MIRC_A_USB_FLG] <= 1'b1;                       // R10 R3
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control B: USB token sources
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_b_q <= `MIRC_RST_BYTE;
      end else begin
         if (wr_ctrl_b) begin
            ctrl_b_q <= wbyte & `MIRC_CTRL_C_MASK;                   // R16
         end
         for (int i = 0; i < 3; i++) begin
            if (usb_token_req_i[i]) begin
               ctrl_b_q[`MIRC_B_FLG_LO + i] <= 1'b1;                 // R4
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Grouped timer match flags and enables
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         grp_q <= `MIRC_RST_BYTE;
      end else begin
         if (wr_grp) begin
            grp_q <= wbyte & `MIRC_GRP_MASK;                         // R6 R16
         end
         for (int i = 0; i < 4; i++) begin
            if (tmr_hit[i]) begin
               grp_q[`MIRC_G_FLG_LO + i] <= 1'b1;                    // R6 R4
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control C: low voltage, serial module and grouped flag
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_c_q <= `MIRC_RST_BYTE;
      end else begin
         if (wr_ctrl_c) begin
            ctrl_c_q <= wbyte & `MIRC_CTRL_C_MASK;                   // R16
         end
         if (low_voltage_detector_req_i) begin
            ctrl_c_q[`MIRC_C_LV_FLG] <= 1'b1;                        // R13 R3
         end
         if (serial_module_req_i) begin
            ctrl_c_q[`MIRC_C_SER_FLG] <= 1'b1;                       // R14 R3
         end
         if (grp_any) begin
            ctrl_c_q[`MIRC_C_GRP_FLG] <= 1'b1;                       // R17
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request gating and program suspension
   assign grp_any = |(grp_q[`MIRC_G_FLG_LO +: 4] & grp_q[`MIRC_G_EN_LO +: 4]);

   // One gated request per source
   assign src_req[0] = gated(ctrl_a_q[`MIRC_A_USB_FLG],
                             ctrl_a_q[`MIRC_A_USB_EN]);
   assign src_req[1] = gated(ctrl_a_q[`MIRC_A_PIN_A_FLG],
                             ctrl_a_q[`MIRC_A_PIN_A_EN]);
   assign src_req[2] = gated(ctrl_a_q[`MIRC_A_PIN_B_FLG],
                             ctrl_a_q[`MIRC_A_PIN_B_EN]);
   // USB token sources share one gating pattern
   for (genvar k = 0; k < 3; k++) begin : g_tok
      assign src_req[3 + k] = gated(ctrl_b_q[`MIRC_B_FLG_LO + k],
                                    ctrl_b_q[`MIRC_B_EN_LO + k]);
   end
   assign src_req[6] = gated(ctrl_c_q[`MIRC_C_LV_FLG],
                             ctrl_c_q[`MIRC_C_LV_EN]);           // R13
   assign src_req[7] = gated(ctrl_c_q[`MIRC_C_SER_FLG],
                             ctrl_c_q[`MIRC_C_SER_EN]);          // R14
   assign src_req[8] = gated(ctrl_c_q[`MIRC_C_GRP_FLG],
                             ctrl_c_q[`MIRC_C_GRP_EN]);
   assign any_req = ctrl_a_q[`MIRC_A_GIE] & (|src_req);             // R15
   assign accept  = (state_q == MIRC_ST_RUN) & any_req;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= MIRC_ST_RUN;
      end else begin
         case (state_q)
            MIRC_ST_RUN: begin
               if (accept) begin
                  state_q <= MIRC_ST_SUSPEND;                        // R1
               end
            end
            MIRC_ST_SUSPEND: begin
               if (service_done_i) begin
                  state_q <= MIRC_ST_RUN;
               end
            end
            default: state_q <= MIRC_ST_RUN;
         endcase
      end
   end

   assign cpu_irq_o      = any_req;                                  // R15
   assign main_suspend_o = (state_q == MIRC_ST_SUSPEND);             // R1
   assign state_o        = state_q;

   ////////////////////////////////////////////////////////////////////////
   // Sticky event status, write one to clear, set wins
   assign ev_set = {accept,
                    ~ctrl_c_q[`MIRC_C_GRP_FLG] & grp_any,
                    low_voltage_detector_req_i,
                    serial_module_req_i,
                    usb_serial_engine_req_i,
                    pin_hit[1],
                    pin_hit[0]};

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ev_status_q <= `MIRC_EV_RST;
      end else begin
         if (wr_status) begin
            ev_status_q <= (ev_status_q & ~wbyte[6:0]) | ev_set;
         end else begin
            ev_status_q <= ev_status_q | ev_set;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ev_mask_q <= `MIRC_EV_RST;
      end else if (wr_mask) begin
         ev_mask_q <= wbyte[6:0];
      end
   end

   assign irq_o = |(ev_status_q & ev_mask_q);
endmodule

//--- testbench/mirc_intc_assertions.sv
// Port checks of the interrupt request control
`timescale 1ns/1ps
`include "mirc_params.svh"
module mirc_chk (
   input wire logic        ref_clk_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic        service_done_i,
   input wire logic        cpu_irq_o,
   input wire logic        main_suspend_o,
   input wire mirc_pkg::mirc_state_t state_o
);
   import mirc_pkg::*;
   logic rd;
   logic gie_q;
   assign rd = psel_i & penable_i & ~pwrite_i;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////
   // Copy of the global enable
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) gie_q <= 1'b0;
      else if (psel_i & penable_i & pwrite_i
               & (paddr_i == `MIRC_OFF_CTRL_A)) gie_q <= pwdata_i[0];
   end
   sequence s_accept;
      cpu_irq_o && !main_suspend_o;
   endsequence
   sequence s_done;
      main_suspend_o && service_done_i;
   endsequence
   AST_EDGE_RD: assert property (
      rd && paddr_i == `MIRC_OFF_EDGE |-> prdata_o[31:4] == 28'h000_0000)
      else $error("edge upper bits set");
   AST_CTLA_RD: assert property (
      rd && paddr_i == `MIRC_OFF_CTRL_A |-> !prdata_o[7])
      else $error("control a bit 7 set");
   AST_CTLC_RD: assert property (
      rd && paddr_i == `MIRC_OFF_CTRL_C |-> !prdata_o[7] && !prdata_o[3])
      else $error("control c gap bits set");
   AST_UNMAPPED: assert property (
      psel_i && penable_i && paddr_i > `MIRC_OFF_MASK
      |-> pslverr_o && prdata_o == 32'h0000_0000)
      else $error("unmapped access not refused");
   AST_RST_QUIET: assert property (
      $fell(sys_rst_i) |-> !cpu_irq_o && !main_suspend_o)
      else $error("request after reset");
   AST_ENTER: assert property (s_accept |=> main_suspend_o)
      else $error("accept without suspend");
   AST_LEAVE: assert property (s_done |=> !main_suspend_o)
      else $error("suspend kept after service");
   AST_STATE: assert property (
      main_suspend_o == (state_o == MIRC_ST_SUSPEND))
      else $error("state and suspend differ");
   AST_GIE: assert property (cpu_irq_o |-> gie_q)
      else $error("request with global enable off");
endmodule
bind mirc_intc mirc_chk u_chk (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .service_done_i,
   .cpu_irq_o, .main_suspend_o, .state_o);

//--- testbench/mirc_core_model.sv
// Core stand-in that services an accepted request
`timescale 1ns/1ps
module mirc_core_model (
   input  wire logic       ref_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       main_suspend_i,
   input  wire logic       cpu_irq_i,
   input  wire logic [2:0] delay_i,
   output logic            service_done_o
);
   logic [2:0] wait_q;
   ////////////////////////////////////////
   // Handler returns only once its request is gone
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wait_q         <= 3'h0;
         service_done_o <= 1'b0;
      end else begin
         service_done_o <= 1'b0;
         if (!main_suspend_i || cpu_irq_i || service_done_o) begin
            wait_q <= 3'h0;
         end else if (wait_q == delay_i) begin
            service_done_o <= 1'b1;
         end else begin
            wait_q <= wait_q + 3'h1;
         end
      end
   end
endmodule

//--- testbench/mirc_intc_test.sv
// Self-checking bench of the interrupt request control
`timescale 1ns/1ps
`include "mirc_params.svh"
module mirc_intc_test;
   import mirc_pkg::*;
   logic        ref_clk_i   = 1'b0;
   logic        sys_rst_i   = 1'b1;
   logic        psel_i      = 1'b0;
   logic        penable_i   = 1'b0;
   logic        pwrite_i    = 1'b0;
   logic [11:0] paddr_i     = 12'h000;
   logic [31:0] pwdata_i    = 32'h0000_0000;
   logic [1:0]  pin         = 2'h0;
   logic [9:0]  src         = 10'h000;
   logic [2:0]  delay       = 3'h0;
   logic [31:0] prdata_o;
   logic [31:0] rdata;
   logic        pready_o, pslverr_o, cpu_irq_o, main_suspend_o;
   logic        irq_o, done, err;
   mirc_state_t state;
   int          bad_count   = 0;
   int          comparisons = 0;
   int          seed        = 32'h0000_d27c;
   always #10 ref_clk_i = ~ref_clk_i;
   mirc_intc DUT (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
      .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .external_request_pin_i(pin), .usb_serial_engine_req_i(src[0]),
      .low_voltage_detector_req_i(src[1]), .serial_module_req_i(src[2]),
      .usb_token_req_i(src[5:3]), .timer_p_match_i(src[7:6]),
      .timer_a_match_i(src[9:8]), .service_done_i(done), .cpu_irq_o,
      .main_suspend_o, .state_o(state), .irq_o);
   mirc_core_model u_core (.ref_clk_i, .sys_rst_i,
      .main_suspend_i(main_suspend_o), .cpu_irq_i(cpu_irq_o),
      .delay_i(delay), .service_done_o(done));
   ////////////////////////////////////////
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= {24'h00_0000, d};
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      @(posedge ref_clk_i);
      for (int n = 0; n < 64 && pready_o !== 1'b1; n++)
         @(posedge ref_clk_i);
      rdata = prdata_o;
      err   = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 8'h00);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic serve;
      @(posedge ref_clk_i);
      #1 chk(main_suspend_o, 1);
      apb(1'b1, `MIRC_OFF_CTRL_A, 8'h00);
      for (int n = 0; n < 40 && main_suspend_o !== 1'b0; n++)
         @(posedge ref_clk_i);
      chk(main_suspend_o, 0);
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Flag location of each source line
   function automatic logic [11:0] src_addr(input int i);
      if (i == 0) return `MIRC_OFF_CTRL_A;
      if (i < 3) return `MIRC_OFF_CTRL_C;
      if (i < 6) return `MIRC_OFF_CTRL_B;
      return `MIRC_OFF_GROUPED;
   endfunction
   function automatic int src_bit(input int i);
      if (i < 2) return 6;
      if (i < 6) return (i == 2) ? 5 : i + 1;
      return (i < 8) ? 4 + 2 * (i - 6) : 5 + 2 * (i - 8);
   endfunction
   // Whole run needs a few hundred cycles
   initial begin
      #400_000;
      bad_count++;
      end_of_test();
   end
   initial begin
      int w;
      logic [7:0] a_val;
      repeat (20) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      for (int a = 0; a < 20; a += 4) begin
         rd(12'(a));
         chk(rdata, 0);
      end
      apb(1'b1, `MIRC_OFF_EDGE, 8'hff);
      rd(`MIRC_OFF_EDGE);
      chk(rdata, 32'h0000_000f);
      apb(1'b1, 12'h01c, 8'hff);
      rd(12'h01c);
      chk({rdata[30:0], err}, 32'h0000_0001);
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 2; p++) begin
            apb(1'b1, `MIRC_OFF_EDGE, 8'(s << (2 * p)));
            for (int v = 1; v >= 0; v--) begin
               pin[p] <= v[0];
               repeat (3) @(posedge ref_clk_i);
               rd(`MIRC_OFF_CTRL_A);
               chk(rdata, ((s >> (1 - v)) & 1) << (4 + p));
               apb(1'b1, `MIRC_OFF_CTRL_A, 8'h00);
            end
         end
      end
      for (int i = 0; i < 10; i++) begin
         w = 1 + ($random(seed) & 3);
         src[i] <= 1'b1;
         repeat (w) @(posedge ref_clk_i);
         src[i] <= 1'b0;
         rd(src_addr(i));
         chk(rdata, 1 << src_bit(i));
         rd(`MIRC_OFF_CTRL_C);
         if (i > 5) chk(rdata, 0);
         apb(1'b1, src_addr(i), 8'h00);
         rd(src_addr(i));
         chk(rdata, 0);
      end
      apb(1'b1, `MIRC_OFF_STATUS, 8'h7f);
      delay <= 3'($random(seed));
      apb(1'b1, `MIRC_OFF_GROUPED, 8'h01);
      src[6] <= 1'b1;
      apb(1'b1, `MIRC_OFF_CTRL_C, 8'h01);
      src[6] <= 1'b0;
      rd(`MIRC_OFF_CTRL_C);
      chk(rdata, 32'h0000_0011);
      #1 chk(cpu_irq_o, 0);
      apb(1'b1, `MIRC_OFF_CTRL_A, 8'h01);
      #1 chk(cpu_irq_o, 1);
      serve();
      rd(`MIRC_OFF_STATUS);
      chk(rdata, 32'h0000_0060);
      chk(irq_o, 0);
      apb(1'b1, `MIRC_OFF_MASK, 8'h40);
      #1 chk(irq_o, 1);
      apb(1'b1, `MIRC_OFF_STATUS, 8'h40);
      #1 chk(irq_o, 0);
      apb(1'b1, `MIRC_OFF_GROUPED, 8'h00);
      apb(1'b1, `MIRC_OFF_CTRL_C, 8'h00);
      apb(1'b1, `MIRC_OFF_EDGE, 8'h01);
      apb(1'b1, `MIRC_OFF_CTRL_A, 8'h01);
      pin[0] <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      #1 chk(cpu_irq_o, 0);
      apb(1'b1, `MIRC_OFF_CTRL_A, 8'h13);
      #1 chk(cpu_irq_o, 1);
      serve();
      // One USB token source picked at random, then low voltage, serial, USB engine and pin B, each alone behind its own enable
      for (int k = 0; k < 5; k++) begin
         w = $random(seed) & 3;
         if (k == 0) apb(1'b1, `MIRC_OFF_CTRL_B, 8'(8'h11 << (w % 3)));
         if (k == 1) apb(1'b1, `MIRC_OFF_CTRL_C, 8'h44);
         if (k == 2) apb(1'b1, `MIRC_OFF_CTRL_C, 8'h22);
         a_val = (k == 3) ? 8'h49 : (k == 4) ? 8'h25 : 8'h01;
         #1 chk(cpu_irq_o, 0);
         apb(1'b1, `MIRC_OFF_CTRL_A, a_val);
         #1 chk(cpu_irq_o, 1);
         serve();
         apb(1'b1, (k == 0) ? `MIRC_OFF_CTRL_B : `MIRC_OFF_CTRL_C, 8'h00);
      end
      end_of_test();
   end
endmodule
